// ### cbiu_pkg.sv
package cbiu_pkg;
   // ----------------------------------------------------------------
   // Address formation
   // ----------------------------------------------------------------
   localparam int ADDR_W = 20;
   localparam int SEG_SHIFT = 4;
   localparam logic [19:0] RESET_ADDR = 20'hffff0;
   localparam logic [15:0] RESET_CS = 16'hffff;
   localparam logic [15:0] RESET_IP = 16'h0000;
   localparam logic [19:0] VEC_TOP = 20'h003ff;
   localparam int VEC_SHIFT = 2;

   // ----------------------------------------------------------------
   // Queue
   // ----------------------------------------------------------------
   localparam int QUEUE_DEPTH = 6;
   localparam int FETCH_ROOM = 2;

   // ----------------------------------------------------------------
   // Queue status codes
   // ----------------------------------------------------------------
   localparam logic [1:0] QS_IDLE = 2'h0;
   localparam logic [1:0] QS_FIRST = 2'h1;
   localparam logic [1:0] QS_FLUSH = 2'h2;
   localparam logic [1:0] QS_NEXT = 2'h3;

   // ----------------------------------------------------------------
   // Segment selectors
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      CBIU_SEG_EXTRA = 2'h0,
      CBIU_SEG_STACK = 2'h1,
      CBIU_SEG_CODE = 2'h2,
      CBIU_SEG_DATA = 2'h3
   } cbiu_seg_e;

   // Operand reference kinds from the execute unit
   typedef enum logic [2:0] {
      CBIU_REF_VAR = 3'h0,
      CBIU_REF_STACK = 3'h1,
      CBIU_REF_STR_SRC = 3'h2,
      CBIU_REF_STR_DST = 3'h3,
      CBIU_REF_FRAME = 3'h4,
      CBIU_REF_VECTOR = 3'h5
   } cbiu_ref_e;

   // ----------------------------------------------------------------
   // Maximum-mode status encodings
   // ----------------------------------------------------------------
   localparam logic [2:0] ST_INTA = 3'h0;
   localparam logic [2:0] ST_IO_RD = 3'h1;
   localparam logic [2:0] ST_IO_WR = 3'h2;
   localparam logic [2:0] ST_HALT = 3'h3;
   localparam logic [2:0] ST_FETCH = 3'h4;
   localparam logic [2:0] ST_MEM_RD = 3'h5;
   localparam logic [2:0] ST_MEM_WR = 3'h6;
   localparam logic [2:0] ST_PASSIVE = 3'h7;

   // ----------------------------------------------------------------
   // Bus cycle states, Gray along T1-T2-T3-T4
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      CBIU_TI = 3'h0,
      CBIU_T1 = 3'h1,
      CBIU_T2 = 3'h3,
      CBIU_T3 = 3'h2,
      CBIU_T4 = 3'h6
   } cbiu_state_e;

   // Three-flop pin synchroniser length
   localparam int SYNC_LEN = 3;
endpackage

// ### cbiu_queue.sv
module cbiu_queue #(
   parameter int DEPTH = cbiu_pkg::QUEUE_DEPTH,
   parameter int ROOM = cbiu_pkg::FETCH_ROOM
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Control
   input wire logic flush,
   // Fill side: one or two bytes per push, low byte first
   input wire logic push,
   input wire logic push_two,
   input wire logic [15:0] push_data,
   // Drain side
   input wire logic pop,
   output logic [7:0] head,
   output logic head_valid,
   output logic room_for_word
);
   localparam int CW = $clog2(DEPTH + 1);
   localparam int PW = $clog2(DEPTH);

   if (DEPTH < ROOM || ROOM != 2) begin : gen_bad_depth
      $error("cbiu_queue: depth must hold a word");
   end

   logic [7:0] mem [DEPTH];
   logic [PW-1:0] rd, wr;
   logic [CW-1:0] cnt;
   logic [PW-1:0] next_rd, next_wr;
   logic [CW-1:0] next_cnt;
   logic do_pop;
   logic [1:0] n_in;

   function automatic logic [PW-1:0] inc(input logic [PW-1:0] p);
      inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction

   // Head reads straight from storage, so an empty queue shows its first byte at once
   assign head = mem[rd];
   assign head_valid = (cnt != '0);
   assign room_for_word = (cnt <= CW'(DEPTH - ROOM));
   assign do_pop = pop && head_valid;
   assign n_in = push ? (push_two ? 2'h2 : 2'h1) : 2'h0;

   always_comb begin
      next_rd = rd;
      next_wr = wr;
      next_cnt = cnt;
      if (flush) begin
         next_rd = '0;
         next_wr = '0;
         next_cnt = '0;
      end else begin
         if (do_pop) begin
            next_rd = inc(rd);
         end
         if (push) begin
            next_wr = push_two ? inc(inc(wr)) : inc(wr);
         end
         next_cnt = cnt + CW'(n_in) - CW'(do_pop);
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd <= '0;
         wr <= '0;
         cnt <= '0;
      end else begin
         rd <= next_rd;
         wr <= next_wr;
         cnt <= next_cnt;
      end
   end

   // Storage has no reset; only pointers define validity
   always_ff @(posedge clk) begin
      if (push && !flush) begin
         mem[wr] <= push_data[7:0];
         if (push_two) begin
            mem[inc(wr)] <= push_data[15:8];
         end
      end
   end
endmodule

// ### cbiu_top.sv
// What this block does
// - All state is static flops; clock may stop or single-step without loss.
// - Instruction queue holds up to six prefetched bytes.
// - Start a word fetch whenever the queue has room for two bytes and no operand request or branch is pending.
// - Queue hands bytes to the execute unit in FIFO order.
// - First byte into an empty queue is visible to execute unit immediately.
// - Execute unit gives offsets; this unit relocates and moves operands both ways.
// - Output address is 20 bits wide.
// - Segments start on 16-byte boundaries and span 64K bytes.
// - Fetches use code base plus offset; stack uses stack base; no override.
// - Data default, extra for string destination, stack default for frame pointer.
// - Word operands: low byte at lower address, high byte next.
// - Even word is one access; odd word splits into two.
// - Code always fetched as words, byte-selected internally.
// - Even bytes on low lane, odd bytes on high lane.
// - Drive high-byte enable with low address bit to pick bytes.
// - After reset execution begins at FFFF0.
// - Vectors in 0-3FF: 256 entries, offset word then code base word.
// - Mode strap picks minimum or maximum pin functions.
// - Minimum mode drives transceiver enable, direction and address latch strobe.
// - Maximum mode drives three status lines, lock, queue status; request/grant stays idle.
// - Queue status 10 on flush, 11 on subsequent byte taken.
// - Bus cycle is T1..T4, waits between T3 and T4 while not ready.
// - Status codes: inta, io rd, io wr, halt, fetch, mem rd, mem wr, passive.
module cbiu_top (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Pins from the system
   input wire logic mode_strap,
   input wire logic ready,
   input wire logic [15:0] data_in,
   input wire logic [1:0] req_grant_in,
   // Execute unit: queue drain and branch
   input wire logic eu_pop,
   input wire logic eu_branch,
   input wire logic [15:0] eu_branch_cs,
   input wire logic [15:0] eu_branch_ip,
   // Execute unit: operand request
   input wire logic eu_req,
   input wire logic eu_write,
   input wire logic eu_word,
   input wire logic eu_io,
   input wire logic eu_lock,
   input wire logic [2:0] eu_ref,
   input wire logic eu_override,
   input wire logic [1:0] eu_override_seg,
   input wire logic [15:0] eu_offset,
   input wire logic [15:0] eu_wdata,
   input wire logic [7:0] eu_vector,
   // Segment bases from the execute unit
   input wire logic [15:0] data_segment_base,
   input wire logic [15:0] extra_segment_base,
   input wire logic [15:0] stack_segment_base,
   // Execute unit answers
   output logic [7:0] eu_byte,
   output logic eu_byte_valid,
   output logic eu_done,
   output logic [15:0] eu_rdata,
   output logic [15:0] code_segment_base,
   output logic [15:0] instruction_offset,
   // Local bus
   output logic [19:0] addr,
   output logic low_address_bit,
   output logic high_byte_enable_n,
   output logic [15:0] data_out,
   output logic data_oe_n,
   output logic addr_latch_strobe,
   output logic read_n,
   output logic write_n,
   output logic io_mem_n,
   output logic transceiver_enable_n,
   output logic transmit_receive_dir,
   // Maximum-mode status
   output logic bus_status_bit0,
   output logic bus_status_bit1,
   output logic bus_status_bit2,
   output logic lock_n,
   output logic [1:0] queue_status,
   output logic [1:0] req_grant_out
);
   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [cbiu_pkg::SYNC_LEN-1:0] rdy_sh, mode_sh;
   logic rdy_s, mode_s, mode_hold;
   logic next_rdy_s, next_mode;

   always_comb begin
      next_rdy_s = (rdy_sh[1] == rdy_sh[2]) ? rdy_sh[2] : rdy_s;
      next_mode = (mode_sh[1] == mode_sh[2]) ? mode_sh[2] : mode_hold;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdy_sh <= '0;
         mode_sh <= '0;
         rdy_s <= 1'b0;
         mode_hold <= 1'b0;
      end else begin
         rdy_sh <= {rdy_sh[1:0], ready};
         mode_sh <= {mode_sh[1:0], mode_strap};
         rdy_s <= next_rdy_s;
         mode_hold <= next_mode;
      end
   end
   assign mode_s = mode_hold;

   // ----------------------------------------------------------------
   // Prefetch queue
   // ----------------------------------------------------------------
   logic q_push, q_two, q_valid, q_room, q_flush;
   logic [15:0] q_data;

   cbiu_queue #(
      .DEPTH(cbiu_pkg::QUEUE_DEPTH),
      .ROOM(cbiu_pkg::FETCH_ROOM)
   ) u_queue (
      .clk(clk),
      .rstn(rstn),
      .flush(q_flush),
      .push(q_push),
      .push_two(q_two),
      .push_data(q_data),
      .pop(eu_pop),
      .head(eu_byte),
      .head_valid(eu_byte_valid),
      .room_for_word(q_room)
   );

   // ----------------------------------------------------------------
   // Bus sequencer state
   // ----------------------------------------------------------------
   cbiu_pkg::cbiu_state_e st, next_st;
   logic [15:0] cs, ip, fetch_ip, next_cs, next_ip, next_fetch_ip;
   logic is_fetch, next_is_fetch, second, next_second, op_busy, next_op_busy;
   logic vec_phase, next_vec_phase;
   logic [15:0] rbuf, next_rbuf;
   logic [19:0] cyc_addr, next_cyc_addr;
   logic [2:0] cyc_st, next_cyc_st;
   logic cyc_bhe_n, next_cyc_bhe_n;
   logic [15:0] cyc_wdata, next_cyc_wdata;
   logic done_p, next_done;

   // Segment selection
   cbiu_pkg::cbiu_seg_e seg;
   logic [15:0] seg_base, op_off;
   logic [19:0] op_addr, fetch_addr;

   always_comb begin
      unique case (cbiu_pkg::cbiu_ref_e'(eu_ref))
         cbiu_pkg::CBIU_REF_STACK: seg = cbiu_pkg::CBIU_SEG_STACK;
         cbiu_pkg::CBIU_REF_STR_DST: seg = cbiu_pkg::CBIU_SEG_EXTRA;
         cbiu_pkg::CBIU_REF_FRAME: seg = (eu_override && eu_override_seg !=
            2'h1) ? cbiu_pkg::cbiu_seg_e'(eu_override_seg) : cbiu_pkg::CBIU_SEG_STACK;
         cbiu_pkg::CBIU_REF_VECTOR: seg = cbiu_pkg::CBIU_SEG_EXTRA;
         default: seg = (eu_override && eu_override_seg != 2'h3) ?
            cbiu_pkg::cbiu_seg_e'(eu_override_seg) : cbiu_pkg::CBIU_SEG_DATA;
      endcase
      unique case (seg)
         cbiu_pkg::CBIU_SEG_EXTRA: seg_base = extra_segment_base;
         cbiu_pkg::CBIU_SEG_STACK: seg_base = stack_segment_base;
         cbiu_pkg::CBIU_SEG_CODE: seg_base = cs;
         cbiu_pkg::CBIU_SEG_DATA: seg_base = data_segment_base;
      endcase
      // Vector table lives at base zero; the second word follows the first
      op_off = (eu_ref == cbiu_pkg::CBIU_REF_VECTOR) ?
         {6'h00, eu_vector, vec_phase, 1'b0} : eu_offset;
      if (eu_ref == cbiu_pkg::CBIU_REF_VECTOR) begin
         op_addr = {4'h0, op_off};
      end else if (eu_io) begin
         op_addr = {4'h0, op_off};
      end else begin
         op_addr = ({seg_base, 4'h0} + {4'h0, op_off});
      end
      // Code fetch always on an even word address
      fetch_addr = {cs, 4'h0} + {4'h0, fetch_ip[15:1], 1'b0};
   end

   logic odd_word;
   assign odd_word = eu_word && op_addr[0];

   always_comb begin
      next_st = st;
      next_cs = cs;
      next_ip = ip;
      next_fetch_ip = fetch_ip;
      next_is_fetch = is_fetch;
      next_second = second;
      next_op_busy = op_busy;
      next_vec_phase = vec_phase;
      next_rbuf = rbuf;
      next_cyc_addr = cyc_addr;
      next_cyc_st = cyc_st;
      next_cyc_bhe_n = cyc_bhe_n;
      next_cyc_wdata = cyc_wdata;
      next_done = 1'b0;
      q_push = 1'b0;
      q_two = 1'b0;
      q_data = data_in;
      q_flush = eu_branch;
      if (eu_branch) begin
         next_cs = eu_branch_cs;
         next_ip = eu_branch_ip;
         next_fetch_ip = eu_branch_ip;
      end else if (eu_pop && eu_byte_valid) begin
         next_ip = ip + 16'h0001;
      end
      unique case (st)
         cbiu_pkg::CBIU_TI, cbiu_pkg::CBIU_T4: begin
            next_st = cbiu_pkg::CBIU_TI;
            if (st == cbiu_pkg::CBIU_T4 && !is_fetch && second) begin
               // Second half of a split word: upper byte at the next address
               next_st = cbiu_pkg::CBIU_T1;
               next_second = 1'b0;
               next_cyc_addr = cyc_addr + 20'h00001;
               next_cyc_bhe_n = 1'b1;
               next_cyc_wdata = {8'h00, cyc_wdata[7:0]};
            end else if (eu_req && !op_busy && !eu_branch) begin
               next_st = cbiu_pkg::CBIU_T1;
               next_is_fetch = 1'b0;
               next_op_busy = 1'b1;
               next_cyc_addr = op_addr;
               next_second = odd_word;
               // Byte lanes from address bit zero and operand width
               next_cyc_bhe_n = !(op_addr[0] || eu_word);
               next_cyc_wdata = op_addr[0] ? {eu_wdata[7:0], eu_wdata[15:8]} : eu_wdata;
               if (eu_ref == cbiu_pkg::CBIU_REF_VECTOR && !eu_write) begin
                  next_cyc_st = cbiu_pkg::ST_MEM_RD;
               end else if (eu_io) begin
                  next_cyc_st = eu_write ? cbiu_pkg::ST_IO_WR : cbiu_pkg::ST_IO_RD;
               end else begin
                  next_cyc_st = eu_write ? cbiu_pkg::ST_MEM_WR : cbiu_pkg::ST_MEM_RD;
               end
            end else if (q_room && !eu_branch && !eu_req) begin
               next_st = cbiu_pkg::CBIU_T1;
               next_is_fetch = 1'b1;
               next_cyc_addr = fetch_addr;
               next_cyc_bhe_n = 1'b0;
               next_cyc_st = cbiu_pkg::ST_FETCH;
            end else begin
               next_cyc_st = cbiu_pkg::ST_PASSIVE;
            end
         end
         cbiu_pkg::CBIU_T1: next_st = cbiu_pkg::CBIU_T2;
         cbiu_pkg::CBIU_T2: next_st = cbiu_pkg::CBIU_T3;
         cbiu_pkg::CBIU_T3: begin
            if (rdy_s) begin
               next_st = cbiu_pkg::CBIU_T4;
               if (is_fetch) begin
                  // A word fetched for the stream before a branch is stale
                  if (!eu_branch && cyc_addr == fetch_addr) begin
                     q_push = 1'b1;
                     q_two = !fetch_ip[0];
                     q_data = fetch_ip[0] ? {8'h00, data_in[15:8]} : data_in;
                     next_fetch_ip = {fetch_ip[15:1], 1'b0} + 16'h0002;
                  end
               end else if (cyc_addr[0]) begin
                  // Odd byte, or low byte of a split word, rides the upper lane
                  next_rbuf = {rbuf[15:8], data_in[15:8]};
               end else if (odd_word) begin
                  next_rbuf = {data_in[7:0], rbuf[7:0]};
               end else begin
                  next_rbuf = (cyc_bhe_n) ? {rbuf[15:8], data_in[7:0]} :
                     data_in;
               end
               if (!is_fetch && !second) begin
                  next_done = 1'b1;
                  next_op_busy = 1'b0;
                  if (eu_ref == cbiu_pkg::CBIU_REF_VECTOR) begin
                     next_vec_phase = !vec_phase;
                  end
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st <= cbiu_pkg::CBIU_TI;
         cs <= cbiu_pkg::RESET_CS;
         ip <= cbiu_pkg::RESET_IP;
         fetch_ip <= cbiu_pkg::RESET_IP;
         is_fetch <= 1'b0;
         second <= 1'b0;
         op_busy <= 1'b0;
         vec_phase <= 1'b0;
         rbuf <= 16'h0000;
         cyc_addr <= cbiu_pkg::RESET_ADDR;
         cyc_st <= cbiu_pkg::ST_PASSIVE;
         cyc_bhe_n <= 1'b1;
         cyc_wdata <= 16'h0000;
         done_p <= 1'b0;
      end else begin
         st <= next_st;
         cs <= next_cs;
         ip <= next_ip;
         fetch_ip <= next_fetch_ip;
         is_fetch <= next_is_fetch;
         second <= next_second;
         op_busy <= next_op_busy;
         vec_phase <= next_vec_phase;
         rbuf <= next_rbuf;
         cyc_addr <= next_cyc_addr;
         cyc_st <= next_cyc_st;
         cyc_bhe_n <= next_cyc_bhe_n;
         cyc_wdata <= next_cyc_wdata;
         done_p <= next_done;
      end
   end

   // ----------------------------------------------------------------
   // Pin stage: every output registered except eu_byte and eu_byte_valid
   // ----------------------------------------------------------------
   logic in_cyc, next_in_cyc, wr_cyc, rd_cyc;
   logic [1:0] next_qs;
   assign next_in_cyc = (next_st != cbiu_pkg::CBIU_TI);
   assign wr_cyc = (next_cyc_st == cbiu_pkg::ST_MEM_WR) ||
      (next_cyc_st == cbiu_pkg::ST_IO_WR);
   assign rd_cyc = next_in_cyc && !wr_cyc;
   assign in_cyc = next_in_cyc;

   always_comb begin
      if (eu_branch) begin
         next_qs = cbiu_pkg::QS_FLUSH;
      end else if (eu_pop && eu_byte_valid) begin
         next_qs = cbiu_pkg::QS_NEXT;
      end else begin
         next_qs = cbiu_pkg::QS_IDLE;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         addr <= cbiu_pkg::RESET_ADDR;
         low_address_bit <= 1'b0;
         high_byte_enable_n <= 1'b1;
         data_out <= 16'h0000;
         data_oe_n <= 1'b1;
         addr_latch_strobe <= 1'b0;
         read_n <= 1'b1;
         write_n <= 1'b1;
         io_mem_n <= 1'b0;
         transceiver_enable_n <= 1'b1;
         transmit_receive_dir <= 1'b0;
         bus_status_bit0 <= 1'b1;
         bus_status_bit1 <= 1'b1;
         bus_status_bit2 <= 1'b1;
         lock_n <= 1'b1;
         queue_status <= cbiu_pkg::QS_IDLE;
         req_grant_out <= 2'h3;
         eu_done <= 1'b0;
         eu_rdata <= 16'h0000;
         code_segment_base <= cbiu_pkg::RESET_CS;
         instruction_offset <= cbiu_pkg::RESET_IP;
      end else begin
         addr <= next_cyc_addr;
         low_address_bit <= next_cyc_addr[0];
         high_byte_enable_n <= next_cyc_bhe_n;
         data_out <= next_cyc_wdata;
         data_oe_n <= !(wr_cyc && in_cyc && next_st != cbiu_pkg::CBIU_T1);
         addr_latch_strobe <= (next_st == cbiu_pkg::CBIU_T1);
         read_n <= !(mode_s && rd_cyc && next_st != cbiu_pkg::CBIU_T1);
         write_n <= !(mode_s && wr_cyc && in_cyc && next_st != cbiu_pkg::CBIU_T1);
         io_mem_n <= (next_cyc_st == cbiu_pkg::ST_IO_RD) ||
            (next_cyc_st == cbiu_pkg::ST_IO_WR);
         transceiver_enable_n <= !(mode_s && in_cyc && next_st != cbiu_pkg::CBIU_T1);
         transmit_receive_dir <= mode_s && wr_cyc;
         // Status passive in minimum mode and outside T1
         {bus_status_bit2, bus_status_bit1, bus_status_bit0} <= (!mode_s &&
            (next_st == cbiu_pkg::CBIU_T1)) ? next_cyc_st : cbiu_pkg::ST_PASSIVE;
         lock_n <= !(!mode_s && eu_lock);
         queue_status <= mode_s ? cbiu_pkg::QS_IDLE : next_qs;
         // Request/grant channels idle; no local master support
         req_grant_out <= 2'h3;
         eu_done <= next_done;
         if (next_done) begin
            eu_rdata <= next_rbuf;
         end
         code_segment_base <= next_cs;
         instruction_offset <= next_ip;
      end
   end
endmodule

// ### cbiu_properties.sv
module cbiu_properties (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Watched pins
   input wire logic mode_strap,
   input wire logic eu_req,
   input wire logic eu_branch,
   input wire logic eu_done,
   input wire logic [19:0] addr,
   input wire logic low_address_bit,
   input wire logic high_byte_enable_n,
   input wire logic addr_latch_strobe,
   input wire logic write_n,
   input wire logic transmit_receive_dir,
   input wire logic bus_status_bit0,
   input wire logic bus_status_bit1,
   input wire logic bus_status_bit2,
   input wire logic [1:0] queue_status
);
   logic [2:0] st;
   assign st = {bus_status_bit2, bus_status_bit1, bus_status_bit0};
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   a_cycle_four: assert property (addr_latch_strobe |=> !addr_latch_strobe [*3])
      else $error("short bus cycle");
   a_addr_stands: assert property (addr_latch_strobe |=> $stable(addr) [*3])
      else $error("address moved in cycle");
   a_fetch_word: assert property (addr_latch_strobe && !mode_strap && st == 3'h4 |->
      !low_address_bit && !high_byte_enable_n) else $error("fetch not a word");
   a_reset_start: assert property ($rose(rstn) |-> ##[0:8]
      addr_latch_strobe && addr == cbiu_pkg::RESET_ADDR) else $error("bad start address");
   a_passive_idle: assert property (!mode_strap && !addr_latch_strobe |-> st == 3'h7)
      else $error("status not passive");
   a_flush_code: assert property (eu_branch && !mode_strap |=> queue_status == 2'h2)
      else $error("no flush code");
   a_dir_write: assert property (!write_n |-> transmit_receive_dir)
      else $error("direction wrong on write");
   a_done_bound: assert property ($rose(eu_req) |-> ##[3:300] eu_done)
      else $error("operand never done");
   c_fetch: cover property (addr_latch_strobe && st == 3'h4);
   c_done: cover property (eu_done);
   c_flush: cover property (queue_status == 2'h2);
endmodule

bind cbiu_top cbiu_properties cbiu_properties_i (.*);

// ### cbiu_mem.sv
module cbiu_mem (
   // Bus from the unit
   input wire logic clk,
   input wire logic mode_strap,
   input wire logic slow,
   input wire logic [19:0] addr,
   input wire logic low_address_bit,
   input wire logic high_byte_enable_n,
   input wire logic [15:0] data_out,
   input wire logic addr_latch_strobe,
   input wire logic write_n,
   input wire logic [2:0] st,
   // Answers
   output logic ready,
   output logic [15:0] data_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [logic [19:0]];
   logic rd = 1'h0;
   int s = 43976;
   // Untouched bytes hold a pattern of their own address
   function automatic logic [7:0] mb(input logic [19:0] a);
      return mem.exists(a) ? mem[a] : a[7:0] ^ {a[11:8], a[19:16]};
   endfunction
   initial begin
      ready = 1'h1;
      data_in = 16'h0;
   end
   always @(posedge clk) begin
      if (addr_latch_strobe)
         rd <= mode_strap || st == 3'h4 || st == 3'h5;
      else if (!write_n)
         rd <= 1'h0;
      if (!write_n && !low_address_bit)
         mem[{addr[19:1], 1'h0}] = data_out[7:0];
      if (!write_n && !high_byte_enable_n)
         mem[{addr[19:1], 1'h1}] = data_out[15:8];
   end
   // Idle lanes toggle so a stale value can never pass
   always @(negedge clk) begin
      ready <= !slow || ($random(s) & 1) != 0;
      data_in <= rd ? {mb({addr[19:1], 1'h1}), mb({addr[19:1], 1'h0})} : ~data_in;
   end
endmodule

// ### cbiu_top_bench.sv
module cbiu_top_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'h0, rstn = 1'h0, mode_strap = 1'h1, slow = 1'h0, eu_pop = 1'h0;
   logic eu_branch = 1'h0, eu_req = 1'h0, eu_write = 1'h0, eu_word = 1'h0, eu_io = 1'h0;
   logic eu_lock = 1'h0, eu_override = 1'h0;
   logic [1:0] req_grant_in = 2'h3, eu_override_seg = 2'h0;
   logic [2:0] eu_ref = 3'h0;
   logic [7:0] eu_vector = 8'h0;
   logic [15:0] eu_branch_cs = 16'h0, eu_branch_ip = 16'h0, eu_offset = 16'h0, eu_wdata = 16'h0;
   logic [15:0] data_segment_base, extra_segment_base, stack_segment_base;
   logic ready, eu_byte_valid, eu_done, low_address_bit, high_byte_enable_n, data_oe_n, lock_n;
   logic addr_latch_strobe, read_n, write_n, io_mem_n, transceiver_enable_n, transmit_receive_dir;
   logic bus_status_bit0, bus_status_bit1, bus_status_bit2;
   logic [1:0] queue_status, req_grant_out;
   logic [2:0] st;
   logic [7:0] eu_byte;
   logic [15:0] data_in, eu_rdata, code_segment_base, instruction_offset, data_out, cs, ip, m;
   logic [19:0] addr;
   int seed = 43976, bad_count = 0, n_checks = 0;
   assign st = {bus_status_bit2, bus_status_bit1, bus_status_bit0};
   cbiu_top cbiu_top_i (.*);
   cbiu_mem cbiu_mem_i (.*);
   initial forever #50 clk = ~clk;
   task automatic complete_run;
      if (bad_count == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string t);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: %s", $time, t);
      end
   endtask
   task automatic wait_hi(ref logic f);
      for (int i = 0; i < 500 && f !== 1'h1; i++)
         @(negedge clk);
      if (f !== 1'h1) begin
         chk(16'h0, 16'h1, "wait timed out");
         complete_run();
      end
   endtask
   // Pops at random moments, back to back at times
   task automatic take(input int n);
      logic p;
      for (int k = 0; k < 3000 && n > 0; k++) begin
         @(negedge clk);
         p = eu_byte_valid === 1'h1 && ($random(seed) & 3) != 0;
         if (p)
            chk({8'h0, eu_byte}, {8'h0, cbiu_mem_i.mb({cs, 4'h0} + ip)}, "queue");
         chk(instruction_offset, ip, "offset");
         ip = ip + 16'(p);
         n = n - int'(p);
         eu_pop = p;
      end
      @(negedge clk);
      eu_pop = 1'h0;
      if (n > 0)
         wait_hi(eu_pop);
   endtask
   task automatic branch(input logic [15:0] c, input logic [15:0] o);
      eu_branch_cs = c;
      eu_branch_ip = o;
      eu_branch = 1'h1;
      @(negedge clk);
      eu_branch = 1'h0;
      cs = c;
      ip = o;
      chk(code_segment_base, c, "branch base");
   endtask
   function automatic logic [15:0] base_of(input logic [2:0] r);
      logic [1:0] g;
      g = r == 3'h1 ? 2'h1 : r == 3'h3 ? 2'h0 : eu_override ? eu_override_seg :
         r == 3'h4 ? 2'h1 : 2'h3;
      return g[1] ? (g[0] ? data_segment_base : cs) : (g[0] ? stack_segment_base : extra_segment_base);
   endfunction
   task automatic op(input logic w, input logic [2:0] r, input logic [19:0] a);
      eu_write = w;
      eu_ref = r;
      eu_req = 1'h1;
      wait_hi(eu_done);
      eu_req = 1'h0;
      m = {{8{eu_word}}, 8'hff};
      if (!w)
         chk(eu_rdata & m, {cbiu_mem_i.mb(a + 20'h1), cbiu_mem_i.mb(a)} & m, "read");
      @(negedge clk);
   endtask
   task automatic ops(input int n, input logic wr);
      logic [2:0] r;
      repeat (n) begin
         eu_word = 1'($random(seed));
         eu_override = 1'($random(seed));
         eu_override_seg = 2'($random(seed));
         eu_offset = 16'({$random(seed)} % 65535);
         eu_wdata = 16'($random(seed));
         r = 3'({$random(seed)} % 5);
         op(1'h0, r, {base_of(r), 4'h0} + eu_offset);
         if (wr) begin
            op(1'h1, r, {base_of(r), 4'h0} + eu_offset);
            op(1'h0, r, {base_of(r), 4'h0} + eu_offset);
            chk(eu_rdata & m, eu_wdata & m, "write back");
         end
      end
   endtask
   initial begin
      data_segment_base = 16'($random(seed));
      extra_segment_base = 16'($random(seed));
      stack_segment_base = 16'($random(seed));
      repeat (20) @(negedge clk);
      chk(code_segment_base, cbiu_pkg::RESET_CS, "reset base");
      chk(instruction_offset, cbiu_pkg::RESET_IP, "reset offset");
      rstn = 1'h1;
      cs = cbiu_pkg::RESET_CS;
      ip = cbiu_pkg::RESET_IP;
      take(24);
      slow = 1'h1;
      branch(16'($random(seed)), 16'h0fff);
      take(11);
      ops(12, 1'h1);
      eu_vector = 8'($random(seed));
      eu_word = 1'h1;
      op(1'h0, 3'h5, {10'h0, eu_vector, 2'h0});
      op(1'h0, 3'h5, {10'h0, eu_vector, 2'h2});
      branch(16'($random(seed)), 16'($random(seed)));
      // Long stall lets the queue fill to its limit before draining
      repeat (80) @(negedge clk);
      take(14);
      rstn = 1'h0;
      mode_strap = 1'h0;
      @(negedge clk);
      rstn = 1'h1;
      cs = cbiu_pkg::RESET_CS;
      ip = cbiu_pkg::RESET_IP;
      take(10);
      branch(16'($random(seed)), 16'h0100);
      ops(5, 1'h0);
      complete_run();
   end
endmodule
